// *** fault_conditioner.sv ***
// One fault input path: two-stage synchroniser, optional noise filter and edge detector.
// Assumes raw may change at any time relative to mclk.
`timescale 1ns/10ps
`include "timer_fault_defines.svh"

module fault_conditioner (
	input  wire logic mclk,
	input  wire logic rstn,
	input  wire logic raw,
	input  wire logic filter_en,
	input  wire logic rising_sel,
	output logic      event_pulse
);

	logic       sync1_ff;
	logic       sync2_ff;
	logic [2:0] hist_ff;
	logic       filt_ff;
	logic       prev_ff;
	logic [2:0] nxt_hist;
	logic       nxt_filt;
	logic       level;
	logic [`FILTER_SAMPLES-1:0] window;

	always_comb begin
		window   = {hist_ff, sync2_ff};
		nxt_hist = {hist_ff[1:0], sync2_ff};
		nxt_filt = filt_ff;
		if ((&window) || (~|window)) begin
			nxt_filt = sync2_ff;
		end
		// Filtered path lags the synchronised input by four mclk cycles, independent of any prescaler.
		level = filter_en ? filt_ff : sync2_ff;
		event_pulse = rising_sel ? (level & ~prev_ff) : (~level & prev_ff);
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
			hist_ff  <= 3'h0;
			filt_ff  <= 1'b0;
			prev_ff  <= 1'b0;
		end else begin
			sync1_ff <= raw;
			sync2_ff <= sync1_ff;
			hist_ff  <= nxt_hist;
			filt_ff  <= nxt_filt;
			prev_ff  <= level;
		end
	end

endmodule

// *** fault_source.sv ***
// Far-side model of the two fault sources feeding the timer.
// Assumes the bench sets the pin and comparator levels; the port drive wins on the pin.
`timescale 1ns/10ps
module fault_source (
	input  wire logic pin_lvl,
	input  wire logic cmp_lvl,
	input  wire logic drv,
	input  wire logic drv_en,
	output logic      ext_irq_pin_i,
	output logic      comparator_out
);
	// The pin reads back its own drive while enabled; the timer takes a software fault from its own port bits.
	assign ext_irq_pin_i  = drv_en ? drv : pin_lvl;
	assign comparator_out = cmp_lvl;
endmodule

// *** timer_fault_defines.svh ***
// Register offsets, field positions, reset values and timing counts of the PWM timer.
// Assumes an APB slave with 32-bit data and byte addresses on paddr.
`ifndef TIMER_FAULT_DEFINES_SVH
`define TIMER_FAULT_DEFINES_SVH

`define ADDR_W          8
`define OFS_MODE        8'h00
`define OFS_CTRL_D      8'h04
`define OFS_HIGH        8'h08
`define OFS_COUNT       8'h0c
`define OFS_CMP_A       8'h10
`define OFS_CMP_B       8'h14
`define OFS_CMP_C       8'h18
`define OFS_CMP_D       8'h1c
`define OFS_PORT        8'h20
`define OFS_PRESCALE    8'h24

`define MODE_RUN_BIT    6
`define CD_GUARD_BIT    0
`define CD_IRQ_EN_BIT   1
`define CD_SRC_CMP_BIT  2
`define CD_FILTER_BIT   3
`define CD_RISING_BIT   4
`define CD_FLAG_BIT     5
`define PORT_DRV_BIT    6
`define PORT_OE_BIT     7

`define TOP_RESET       10'h3ff
`define PRESCALE_RESET  8'h00
`define FILTER_SAMPLES  4

`endif

// *** timer_fault_guard.sv ***
// Notes on behaviour
// - Timer tick is a one-cycle enable on mclk, never a clock.
// - With guarding on, a matching edge on the chosen fault input trips protection.
// - A trip clears all output modes; pins then show the port latch bits.
// - The guard enable clears in the same cycle as the output modes.
// - With the fault interrupt enabled, a trip raises the fault interrupt.
// - Fault source is the external pin, or the comparator when selected.
// - Both fault inputs use identical synchronisers and edge detectors.
// - Software can cause a fault by driving the external pin's port bit.
// - The filter output changes only after four equal samples.
// - The filter works only when enabled, adding four mclk cycles.
// - The filter samples on mclk, unaffected by the prescaler.
// - Count and four compares are 10 bits, sharing one 2-bit high byte.
// - A low-byte write loads held high bits and data together.
// - A low-byte read copies the upper two bits into the high byte.
//
// Top of the PWM timer with fault guard and byte-wide access to its 10-bit registers.
// Assumes an APB master on mclk; ext_irq_pin_i and comparator_out are asynchronous.
`timescale 1ns/10ps
`include "timer_fault_defines.svh"

module timer_fault_guard (
	input  wire logic              mclk,
	input  wire logic              rstn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [`ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              ext_irq_pin_i,
	output logic                   ext_irq_pin_o,
	output logic                   ext_irq_pin_oe,
	input  wire logic              comparator_out,
	output logic [5:0]             pwm_pins,
	output logic                   fault_irq
);

	// Bus answer state.
	logic [31:0] prdata_ff;
	logic        pready_ff;
	logic        pslverr_ff;
	logic [1:0]  cap_hi_ff;
	logic [31:0] nxt_prdata;
	logic        nxt_pready;
	logic        nxt_pslverr;
	logic [1:0]  nxt_cap_hi;

	// Software-visible control state.
	timer_fault_pkg::output_mode_e mode_ff [3];
	timer_fault_pkg::output_mode_e nxt_mode [3];
	logic        run_ff;
	logic        nxt_run;
	logic        guard_en_ff;
	logic        nxt_guard_en;
	logic        irq_en_ff;
	logic        nxt_irq_en;
	logic        src_cmp_ff;
	logic        nxt_src_cmp;
	logic        filter_en_ff;
	logic        nxt_filter_en;
	logic        rising_ff;
	logic        nxt_rising;
	logic        flag_ff;
	logic        nxt_flag;
	logic [1:0]  high_ff;
	logic [1:0]  nxt_high;
	logic [7:0]  port_ff;
	logic [7:0]  nxt_port;
	logic [7:0]  prescale_ff;
	logic [7:0]  nxt_prescale;
	logic        irq_ff;
	logic        nxt_irq;
	timer_fault_pkg::guard_state_e guard_st_ff;
	timer_fault_pkg::guard_state_e nxt_guard_st;

	// Timer state.
	timer_fault_pkg::word10_t count_ff;
	timer_fault_pkg::word10_t nxt_count;
	timer_fault_pkg::word10_t cmp_ff [4];
	timer_fault_pkg::word10_t nxt_cmp [4];
	logic [7:0]  div_ff;
	logic [7:0]  nxt_div;
	logic [2:0]  wave_ff;
	logic [2:0]  nxt_wave;
	logic [5:0]  pins_ff;
	logic [5:0]  nxt_pins;

	// Decode and event wires.
	logic        setup;
	logic        done;
	logic        wr_done;
	logic        rd_done;
	logic [31:0] rd_data;
	logic        rd_hit;
	logic [1:0]  rd_hi;
	logic        rd_low;
	logic [2:0]  low_idx;
	logic        low_sel;
	logic        tick;
	logic        ext_raw;
	logic        ext_evt;
	logic        cmp_evt;
	logic        fault_evt;
	logic        trip;
	timer_fault_pkg::word10_t next_cnt;

	// Software drives the pin through its own port bits, and that level also feeds the fault path.
	assign ext_raw = port_ff[`PORT_OE_BIT] ? port_ff[`PORT_DRV_BIT] : ext_irq_pin_i;

	fault_conditioner u_ext_path (
		.mclk        (mclk),
		.rstn        (rstn),
		.raw         (ext_raw),
		.filter_en   (filter_en_ff),
		.rising_sel  (rising_ff),
		.event_pulse (ext_evt)
	);

	fault_conditioner u_cmp_path (
		.mclk        (mclk),
		.rstn        (rstn),
		.raw         (comparator_out),
		.filter_en   (filter_en_ff),
		.rising_sel  (rising_ff),
		.event_pulse (cmp_evt)
	);

	assign fault_evt = src_cmp_ff ? cmp_evt : ext_evt;
	assign trip      = fault_evt && guard_en_ff;

	// Read decode; also names which 10-bit register a low-byte access reaches.
	always_comb begin
		rd_data = 32'h0;
		rd_hit  = 1'b1;
		rd_hi   = 2'h0;
		low_sel = 1'b0;
		low_idx = 3'h0;
		if (paddr == `OFS_MODE) begin
			rd_data = {25'h0, run_ff, mode_ff[2], mode_ff[1], mode_ff[0]};
		end else if (paddr == `OFS_CTRL_D) begin
			rd_data = {26'h0, flag_ff, rising_ff, filter_en_ff, src_cmp_ff, irq_en_ff, guard_en_ff};
		end else if (paddr == `OFS_HIGH) begin
			rd_data = {30'h0, high_ff};
		end else if (paddr == `OFS_COUNT) begin
			rd_data = {24'h0, count_ff[7:0]};
			rd_hi   = count_ff[9:8];
			low_sel = 1'b1;
			low_idx = 3'h4;
		end else if (paddr == `OFS_CMP_A) begin
			rd_data = {24'h0, cmp_ff[0][7:0]};
			rd_hi   = cmp_ff[0][9:8];
			low_sel = 1'b1;
			low_idx = 3'h0;
		end else if (paddr == `OFS_CMP_B) begin
			rd_data = {24'h0, cmp_ff[1][7:0]};
			rd_hi   = cmp_ff[1][9:8];
			low_sel = 1'b1;
			low_idx = 3'h1;
		end else if (paddr == `OFS_CMP_C) begin
			rd_data = {24'h0, cmp_ff[2][7:0]};
			rd_hi   = cmp_ff[2][9:8];
			low_sel = 1'b1;
			low_idx = 3'h2;
		end else if (paddr == `OFS_CMP_D) begin
			rd_data = {24'h0, cmp_ff[3][7:0]};
			rd_hi   = cmp_ff[3][9:8];
			low_sel = 1'b1;
			low_idx = 3'h3;
		end else if (paddr == `OFS_PORT) begin
			rd_data = {24'h0, port_ff};
		end else if (paddr == `OFS_PRESCALE) begin
			rd_data = {24'h0, prescale_ff};
		end else begin
			rd_hit = 1'b0;
		end
	end

	assign setup   = psel && !penable;
	assign done    = psel && penable && pready_ff;
	assign wr_done = done && pwrite && !pslverr_ff;
	assign rd_done = done && !pwrite && !pslverr_ff;
	assign rd_low  = rd_done && low_sel;

	// Bus answer: data and the upper bits are both caught in the setup cycle, so a low byte
	// and the copy into the high byte always come from the same count value.
	always_comb begin
		nxt_pready  = setup;
		nxt_prdata  = prdata_ff;
		nxt_pslverr = 1'b0;
		nxt_cap_hi  = cap_hi_ff;
		if (setup) begin
			nxt_prdata  = pwrite ? 32'h0 : rd_data;
			nxt_pslverr = !rd_hit;
			nxt_cap_hi  = rd_hi;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			prdata_ff  <= 32'h0;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			cap_hi_ff  <= 2'h0;
		end else begin
			prdata_ff  <= nxt_prdata;
			pready_ff  <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			cap_hi_ff  <= nxt_cap_hi;
		end
	end

	// Control registers, the fault flag and the trip.
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			nxt_mode[i] = mode_ff[i];
		end
		nxt_run       = run_ff;
		nxt_guard_en  = guard_en_ff;
		nxt_irq_en    = irq_en_ff;
		nxt_src_cmp   = src_cmp_ff;
		nxt_filter_en = filter_en_ff;
		nxt_rising    = rising_ff;
		nxt_flag      = flag_ff;
		nxt_high      = high_ff;
		nxt_port      = port_ff;
		nxt_prescale  = prescale_ff;
		nxt_guard_st  = guard_st_ff;
		if (wr_done) begin
			if (paddr == `OFS_MODE) begin
				for (int i = 0; i < 3; i++) begin
					nxt_mode[i] = timer_fault_pkg::output_mode_e'(pwdata[2*i +: 2]);
				end
				nxt_run = pwdata[`MODE_RUN_BIT];
			end else if (paddr == `OFS_CTRL_D) begin
				nxt_guard_en  = pwdata[`CD_GUARD_BIT];
				nxt_irq_en    = pwdata[`CD_IRQ_EN_BIT];
				nxt_src_cmp   = pwdata[`CD_SRC_CMP_BIT];
				nxt_filter_en = pwdata[`CD_FILTER_BIT];
				nxt_rising    = pwdata[`CD_RISING_BIT];
				if (pwdata[`CD_FLAG_BIT]) begin
					nxt_flag = 1'b0;
				end
			end else if (paddr == `OFS_HIGH) begin
				nxt_high = pwdata[1:0];
			end else if (paddr == `OFS_PORT) begin
				nxt_port = pwdata[7:0];
			end else if (paddr == `OFS_PRESCALE) begin
				nxt_prescale = pwdata[7:0];
			end
		end
		if (rd_low) begin
			nxt_high = cap_hi_ff;
		end
		// A new event beats a software clear in the same cycle.
		if (fault_evt) begin
			nxt_flag = 1'b1;
		end
		// A trip beats a software write to the output modes or the guard enable in the same cycle.
		if (trip) begin
			for (int i = 0; i < 3; i++) begin
				nxt_mode[i] = timer_fault_pkg::MODE_OFF;
			end
			nxt_guard_en = 1'b0;
		end
		nxt_guard_st = nxt_guard_en ? timer_fault_pkg::GUARD_ARMED : timer_fault_pkg::GUARD_IDLE;
		nxt_irq      = nxt_flag && nxt_irq_en;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < 3; i++) begin
				mode_ff[i] <= timer_fault_pkg::MODE_OFF;
			end
			run_ff       <= 1'b0;
			guard_en_ff  <= 1'b0;
			irq_en_ff    <= 1'b0;
			src_cmp_ff   <= 1'b0;
			filter_en_ff <= 1'b0;
			rising_ff    <= 1'b0;
			flag_ff      <= 1'b0;
			high_ff      <= 2'h0;
			port_ff      <= 8'h0;
			prescale_ff  <= `PRESCALE_RESET;
			irq_ff       <= 1'b0;
			guard_st_ff  <= timer_fault_pkg::GUARD_IDLE;
		end else begin
			for (int i = 0; i < 3; i++) begin
				mode_ff[i] <= nxt_mode[i];
			end
			run_ff       <= nxt_run;
			guard_en_ff  <= nxt_guard_en;
			irq_en_ff    <= nxt_irq_en;
			src_cmp_ff   <= nxt_src_cmp;
			filter_en_ff <= nxt_filter_en;
			rising_ff    <= nxt_rising;
			flag_ff      <= nxt_flag;
			high_ff      <= nxt_high;
			port_ff      <= nxt_port;
			prescale_ff  <= nxt_prescale;
			irq_ff       <= nxt_irq;
			guard_st_ff  <= nxt_guard_st;
		end
	end

	// Timer: divider, counter, compare waves and pin mux. Compare C is the top of the count.
	always_comb begin
		tick     = (div_ff == prescale_ff) && run_ff;
		nxt_div  = (div_ff == prescale_ff) ? 8'h0 : div_ff + 8'h1;
		next_cnt = (count_ff == cmp_ff[2]) ? 10'h0 : count_ff + 10'h1;
		nxt_count = count_ff;
		nxt_wave  = wave_ff;
		for (int i = 0; i < 4; i++) begin
			nxt_cmp[i] = cmp_ff[i];
		end
		if (tick) begin
			nxt_count = next_cnt;
			for (int i = 0; i < 3; i++) begin
				if (next_cnt == 10'h0) begin
					nxt_wave[i] = 1'b1;
				end else if (next_cnt == cmp_ff[(i == 2) ? 3 : i]) begin
					nxt_wave[i] = 1'b0;
				end
			end
		end
		// A software write wins over a tick in the same cycle.
		if (wr_done && low_sel) begin
			if (low_idx == 3'h4) begin
				nxt_count = {high_ff, pwdata[7:0]};
			end else begin
				nxt_cmp[low_idx[1:0]] = {high_ff, pwdata[7:0]};
			end
		end
		for (int i = 0; i < 3; i++) begin
			if (mode_ff[i] == timer_fault_pkg::MODE_OFF) begin
				nxt_pins[2*i] = port_ff[2*i];
			end else if (mode_ff[i] == timer_fault_pkg::MODE_SET) begin
				nxt_pins[2*i] = ~wave_ff[i];
			end else begin
				nxt_pins[2*i] = wave_ff[i];
			end
			if (mode_ff[i] == timer_fault_pkg::MODE_COMP) begin
				nxt_pins[2*i+1] = ~wave_ff[i];
			end else begin
				nxt_pins[2*i+1] = port_ff[2*i+1];
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			div_ff   <= 8'h0;
			count_ff <= 10'h0;
			for (int i = 0; i < 4; i++) begin
				cmp_ff[i] <= (i == 2) ? `TOP_RESET : 10'h0;
			end
			wave_ff  <= 3'h0;
			pins_ff  <= 6'h0;
		end else begin
			div_ff   <= nxt_div;
			count_ff <= nxt_count;
			for (int i = 0; i < 4; i++) begin
				cmp_ff[i] <= nxt_cmp[i];
			end
			wave_ff  <= nxt_wave;
			pins_ff  <= nxt_pins;
		end
	end

	assign prdata         = prdata_ff;
	assign pready         = pready_ff;
	assign pslverr        = pslverr_ff;
	assign ext_irq_pin_o  = port_ff[`PORT_DRV_BIT];
	assign ext_irq_pin_oe = port_ff[`PORT_OE_BIT];
	assign pwm_pins       = pins_ff;
	assign fault_irq      = irq_ff;

endmodule

// *** timer_fault_guard_monitor.sv ***
// Checker of the timer bus answers and fault reporting, bound to the timer top.
// Assumes the master holds each request until pready is sampled high.
`timescale 1ns/10ps
`include "timer_fault_defines.svh"
module timer_fault_guard_monitor (
	input wire logic               mclk,
	input wire logic               rstn,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [`ADDR_W-1:0] paddr,
	input wire logic [31:0]        pwdata,
	input wire logic [31:0]        prdata,
	input wire logic               pready,
	input wire logic               pslverr,
	input wire logic               ext_irq_pin_i,
	input wire logic               ext_irq_pin_o,
	input wire logic               ext_irq_pin_oe,
	input wire logic               comparator_out,
	input wire logic [5:0]         pwm_pins,
	input wire logic               fault_irq
);
	logic       acc;
	logic       mapped;
	logic       wr_ctrl;
	logic       wr_port;
	logic       rd_high;
	logic [1:0] hold_ff;
	logic [1:0] nxt_hold;
	logic       hold_ok_ff;
	logic       nxt_hold_ok;
	logic [1:0] in_ff;
	logic [3:0] since_ff;
	logic [3:0] nxt_since;

	assign acc     = psel && penable && pready;
	assign mapped  = paddr <= `OFS_PRESCALE && paddr[1:0] == 2'h0;
	assign wr_ctrl = acc && pwrite && paddr == `OFS_CTRL_D;
	assign wr_port = acc && pwrite && paddr == `OFS_PORT;
	assign rd_high = acc && !pwrite && paddr == `OFS_HIGH;

	// A low-byte read refills the shared byte with bits not seen here, so comparing stops.
	always_comb begin
		nxt_hold    = hold_ff;
		nxt_hold_ok = hold_ok_ff;
		nxt_since   = (since_ff == 4'hf) ? since_ff : since_ff + 4'h1;
		if (acc && pwrite && paddr == `OFS_HIGH) begin
			nxt_hold    = pwdata[1:0];
			nxt_hold_ok = 1'b1;
		end
		if (acc && !pwrite && paddr >= `OFS_COUNT && paddr <= `OFS_CMP_D) begin
			nxt_hold_ok = 1'b0;
		end
		if ({ext_irq_pin_i, comparator_out} != in_ff) begin
			nxt_since = 4'h0;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			hold_ff    <= 2'h0;
			hold_ok_ff <= 1'b0;
			in_ff      <= 2'h0;
			since_ff   <= 4'hf;
		end else begin
			hold_ff    <= nxt_hold;
			hold_ok_ff <= nxt_hold_ok;
			in_ff      <= {ext_irq_pin_i, comparator_out};
			since_ff   <= nxt_since;
		end
	end

	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_answer;
		pready ##1 !pready;
	endsequence
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);

	a_bus_answer: assert property (s_setup |=> s_answer) else $error("setup without one answer cycle");
	a_ready_cause: assert property (pready |-> $past(psel && !penable)) else $error("answer without setup");
	a_err_decode: assert property (acc |-> pslverr == !mapped) else $error("error flag wrong for address");
	a_err_alone: assert property (pslverr |-> pready) else $error("error flag outside answer");
	a_high_readback: assert property (rd_high && hold_ok_ff |-> prdata == {30'h0, hold_ff})
		else $error("shared high byte lost");
	a_trip_cause: assert property ($rose(fault_irq) && !$past(wr_ctrl) |-> since_ff <= 4'hc)
		else $error("fault without recent input edge");
	a_flag_hold: assert property ($fell(fault_irq) |-> $past(wr_ctrl))
		else $error("fault report dropped by itself");
	a_drive_port: assert property ($changed({ext_irq_pin_o, ext_irq_pin_oe}) |-> $past(wr_port))
		else $error("pin drive moved without write");
endmodule

bind timer_fault_guard timer_fault_guard_monitor u_mon (.mclk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .ext_irq_pin_i, .ext_irq_pin_o, .ext_irq_pin_oe, .comparator_out, .pwm_pins,
	.fault_irq);

// *** timer_fault_guard_test.sv ***
// Self-checking bench of the timer fault guard and its 10-bit byte access.
// Assumes the fault source model sits on the two fault inputs.
`timescale 1ns/10ps
`include "timer_fault_defines.svh"
module timer_fault_guard_test;
	logic               mclk = 1'b0;
	logic               rstn = 1'b0;
	logic               psel = 1'b0;
	logic               penable = 1'b0;
	logic               pwrite = 1'b0;
	logic [`ADDR_W-1:0] paddr = '0;
	logic [31:0]        pwdata = 32'h0;
	logic [31:0]        prdata;
	logic [31:0]        rd;
	logic [5:0]         pwm_pins;
	logic               pready, pslverr, err, fault_irq;
	logic               ext_irq_pin_i, ext_irq_pin_o, ext_irq_pin_oe, comparator_out;
	logic               pin_lvl = 1'b0;
	logic               cmp_lvl = 1'b0;
	int                 n_fail = 0;
	int                 check_count = 0;
	int                 lat [4];
	int                 n;

	// One clock drives everything; the timer tick is only an enable.
	always #4 mclk = ~mclk;

	timer_fault_guard u_dut (.mclk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.ext_irq_pin_i, .ext_irq_pin_o, .ext_irq_pin_oe, .comparator_out, .pwm_pins, .fault_irq);
	fault_source u_src (.pin_lvl, .cmp_lvl, .drv(ext_irq_pin_o), .drv_en(ext_irq_pin_oe), .ext_irq_pin_i,
		.comparator_out);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("checks %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic apb(input logic w, input logic [`ADDR_W-1:0] a, input logic [31:0] d);
		int k;
		@(posedge mclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			n_fail++;
			close_out();
		end
	endtask

	task automatic wr(input logic [`ADDR_W-1:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdc(input logic [`ADDR_W-1:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(rd, e);
	endtask

	task automatic wait_irq();
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (fault_irq !== 1'b1 && n < 40);
		if (fault_irq !== 1'b1) begin
			n_fail++;
			close_out();
		end
	endtask

	// The unselected input rises first and must stay quiet; then the selected one trips.
	task automatic trip(input int i);
		logic [7:0] cd;
		cd = {3'h0, 1'b1, i[1], i[0], 2'h3};
		@(posedge mclk);
		pin_lvl <= 1'b0;
		cmp_lvl <= 1'b0;
		wr(`OFS_MODE, 32'h15);
		wr(`OFS_CTRL_D, {24'h0, cd | 8'h20});
		rdc(`OFS_CTRL_D, {24'h0, cd});
		check(32'(pwm_pins), 32'h2a);
		pin_lvl <= i[0];
		cmp_lvl <= !i[0];
		repeat (20) @(posedge mclk);
		check(32'(fault_irq), 32'h0);
		pin_lvl <= 1'b1;
		cmp_lvl <= 1'b1;
		wait_irq();
		lat[i] = n;
		rdc(`OFS_CTRL_D, {24'h0, cd ^ 8'h21});
		rdc(`OFS_MODE, 32'h0);
		check(32'(pwm_pins), 32'h15);
	endtask

	initial begin
		repeat (2) @(posedge mclk);
		rstn <= 1'b1;
		check(32'({pwm_pins, fault_irq, ext_irq_pin_oe}), 32'h0);
		apb(1'b0, 8'h28, 32'h0);
		check(32'(err), 32'h1);
		check(rd, 32'h0);
		wr(`OFS_PORT, 32'h15);
		// No interrupt code shares the high byte here, so each pair runs whole.
		wr(`OFS_HIGH, 32'h2);
		wr(`OFS_CMP_A, 32'h34);
		wr(`OFS_CMP_B, 32'h56);
		wr(`OFS_HIGH, 32'h1);
		wr(`OFS_COUNT, 32'hcd);
		wr(`OFS_HIGH, 32'h0);
		rdc(`OFS_HIGH, 32'h0);
		rdc(`OFS_CMP_A, 32'h34);
		rdc(`OFS_HIGH, 32'h2);
		rdc(`OFS_COUNT, 32'hcd);
		rdc(`OFS_HIGH, 32'h1);
		rdc(`OFS_CMP_B, 32'h56);
		rdc(`OFS_HIGH, 32'h2);
		for (int i = 0; i < 4; i++) begin
			trip(i);
		end
		check(lat[1], lat[0]);
		check(lat[2], lat[0] + 4);
		check(lat[3], lat[1] + 4);
		wr(`OFS_MODE, 32'h15);
		wr(`OFS_CTRL_D, 32'h2a);
		rdc(`OFS_CTRL_D, 32'h0a);
		pin_lvl <= 1'b0;
		repeat (3) @(posedge mclk);
		pin_lvl <= 1'b1;
		repeat (20) @(posedge mclk);
		check(32'(fault_irq), 32'h0);
		pin_lvl <= 1'b0;
		wait_irq();
		rdc(`OFS_MODE, 32'h15);
		rdc(`OFS_CTRL_D, 32'h2a);
		wr(`OFS_CTRL_D, 32'h33);
		rdc(`OFS_CTRL_D, 32'h13);
		check(32'(fault_irq), 32'h0);
		wr(`OFS_PORT, 32'hd5);
		wait_irq();
		check(32'({ext_irq_pin_oe, ext_irq_pin_o}), 32'h3);
		rdc(`OFS_CTRL_D, 32'h32);
		check(32'(pwm_pins), 32'h15);
		// The running count steps once between the low-byte write and the read behind it.
		wr(`OFS_MODE, 32'h40);
		wr(`OFS_HIGH, 32'h1);
		wr(`OFS_COUNT, 32'hff);
		rdc(`OFS_COUNT, 32'h0);
		rdc(`OFS_HIGH, 32'h2);
		close_out();
	end
endmodule

// *** timer_fault_pkg.sv ***
// Types shared by the PWM timer files.
// Assumes nothing of its surroundings.
package timer_fault_pkg;

	typedef logic [9:0] word10_t;

	typedef enum logic [1:0] {
		MODE_OFF  = 2'h0,
		MODE_COMP = 2'h1,
		MODE_CLR  = 2'h2,
		MODE_SET  = 2'h3
	} output_mode_e;

	typedef enum logic [1:0] {
		GUARD_IDLE  = 2'h1,
		GUARD_ARMED = 2'h2
	} guard_state_e;

endpackage
